// File: design/sadc_pkg.sv
package sadc_pkg;
  // ===========================================
  // register map
  localparam logic [7:0] SADC_OFF_CTRL2   = 8'h00;
  localparam logic [7:0] SADC_OFF_MUXA    = 8'h04;
  localparam logic [7:0] SADC_OFF_MUXB    = 8'h08;
  localparam logic [7:0] SADC_OFF_SCAN    = 8'h0c;
  localparam logic [7:0] SADC_OFF_FORMAT  = 8'h10;
  localparam logic [7:0] SADC_OFF_START   = 8'h14;
  localparam logic [7:0] SADC_OFF_STATUS  = 8'h18;
  localparam logic [7:0] SADC_OFF_IRQEN   = 8'h1c;
  localparam logic [7:0] SADC_OFF_IRQCLR  = 8'h20;
  localparam logic [7:0] SADC_OFF_BUF     = 8'h40;
  localparam logic [7:0] SADC_OFF_BUF_END = 8'h7c;
  // ===========================================
  // control two fields
  localparam int         SADC_REF_SELECT_HI  = 15;
  localparam int         SADC_REF_SELECT_LO  = 13;
  localparam int         SADC_OFFSET_CAL_MODE_B = 12;
  localparam int         SADC_SCAN_B   = 10;
  localparam int         SADC_HALF_FILL_STATUS_B   = 7;
  localparam int         SADC_SEQUENCES_PER_IRQ_HI  = 5;
  localparam int         SADC_SEQUENCES_PER_IRQ_LO  = 2;
  localparam int         SADC_SPLIT_BUFFER_MODE_B   = 1;
  localparam int         SADC_ALTERNATE_MUX_MODE_B   = 0;
  localparam logic [15:0] SADC_CTRL2_WMASK = 16'hf43f;
  localparam logic [15:0] SADC_CTRL2_RST   = 16'h0000;
  // ===========================================
  // reference sources
  typedef enum logic [1:0] {
    SADC_REF_SUPPLY,
    SADC_REF_PIN
  } sadc_ref_t;
  localparam logic [2:0] SADC_REF_SELECT_BOTH_EXT = 3'h3;
  localparam logic [2:0] SADC_REF_SELECT_EXT_LOW  = 3'h2;
  localparam logic [2:0] SADC_REF_SELECT_EXT_HIGH = 3'h1;
  // ===========================================
  // misc
  localparam logic [3:0] SADC_HALF_WORDS = 4'h8;
  localparam int         SADC_IRQ_DONE   = 0;
  localparam int         SADC_IRQ_HALF   = 1;
  localparam logic [1:0] SADC_IRQ_MASK   = 2'h3;
  localparam int         SADC_CONV_CYCLES = 12;
endpackage

// File: design/sadc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl
  import sadc_pkg::*;
#(
  parameter int CHANNELS   = 16,
  parameter int RES_BITS   = 10,
  parameter int BUF_WORDS  = 16,
  parameter int CONV_CYCLES = SADC_CONV_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic [31:0]              prdata,
  output logic [3:0]               pos_channel,
  output logic                     neg_is_ref_low,
  output logic                     neg_channel_one,
  output logic                     sample_hold,
  input  wire logic                conv_done,
  input  wire logic [RES_BITS-1:0] conv_result,
  output logic                     ref_high_choice,
  output logic                     ref_low_choice,
  output logic                     busy,
  output logic                     irq
);
  // ===========================================
  // state
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SAMPLE,
    SADC_WAIT
  } sadc_state_t;

  typedef struct packed {
    sadc_state_t                 state;
    logic [15:0]                 ctrl2;
    logic [8:0]                  mux_a;
    logic [8:0]                  mux_b;
    logic [15:0]                 scan_mask;
    logic [2:0]                  format;
    logic [1:0]                  irq_status;
    logic [1:0]                  irq_en;
    logic                        use_b;
    logic [3:0]                  scan_ch;
    logic [3:0]                  seq_cnt;
    logic [3:0]                  wr_ptr;
    logic                        half;
    logic [BUF_WORDS*RES_BITS-1:0] buffer;
    logic [31:0]                 rdata;
  } sadc_regs_t;

  sadc_regs_t r;
  sadc_regs_t next_r;

  // ===========================================
  // helpers
  function automatic logic [3:0] next_scan(input logic [15:0] mask, input logic [3:0] cur);
    logic [3:0] idx;
    next_scan = cur;
    for (int i = 1; i <= 16; i++) begin
      idx = 4'(cur + 4'(i));
      if (mask[idx] && next_scan == cur) begin
        next_scan = idx;
      end
    end
  endfunction

  // eight output formats: integer, signed integer, fractional, signed
  // fractional, each in 16-bit or 32-bit placement
  function automatic logic [31:0] fmt(input logic [2:0] f, input logic [9:0] v);
    logic [9:0] s;
    s = v ^ 10'h200;
    case (f)
      3'h0: fmt = {22'h0, v};
      3'h1: fmt = {16'h0, {6{s[9]}}, s};
      3'h2: fmt = {16'h0, v, 6'h00};
      3'h3: fmt = {16'h0, s, 6'h00};
      3'h4: fmt = {22'h0, v};
      3'h5: fmt = {{22{s[9]}}, s};
      3'h6: fmt = {v, 22'h0};
      default: fmt = {s, 22'h0};
    endcase
  endfunction

  logic wr_acc;
  logic rd_acc;
  logic [8:0] cur_mux;
  logic [3:0] base;
  logic [3:0] slot;

  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && !penable && !pwrite;
  assign pslverr = 1'b0;
  assign prdata  = r.rdata;
  assign irq     = |(r.irq_status & r.irq_en);
  assign busy    = r.state != SADC_IDLE;
  assign sample_hold = r.state == SADC_SAMPLE;
  assign cur_mux = r.use_b ? r.mux_b : r.mux_a;

  // ===========================================
  // analog steering
  always_comb begin
    case (r.ctrl2[SADC_REF_SELECT_HI:SADC_REF_SELECT_LO])
      SADC_REF_SELECT_BOTH_EXT: begin
        ref_high_choice = 1'b1;
        ref_low_choice  = 1'b1;
      end
      SADC_REF_SELECT_EXT_LOW: begin
        ref_high_choice = 1'b0;
        ref_low_choice  = 1'b1;
      end
      SADC_REF_SELECT_EXT_HIGH: begin
        ref_high_choice = 1'b1;
        ref_low_choice  = 1'b0;
      end
      default: begin
        ref_high_choice = 1'b0;
        ref_low_choice  = 1'b0;
      end
    endcase
    if (r.ctrl2[SADC_OFFSET_CAL_MODE_B]) begin
      pos_channel     = 4'h0;
      neg_is_ref_low  = 1'b1;
      neg_channel_one = 1'b0;
    end else begin
      pos_channel     = r.ctrl2[SADC_SCAN_B] ? r.scan_ch : cur_mux[3:0];
      // negative input: low reference or channel one (differential)
      neg_is_ref_low  = !cur_mux[8] || (ref_low_choice && pos_channel == 4'h1);
      neg_channel_one = !neg_is_ref_low;
    end
  end

  // ===========================================
  // next state
  always_comb begin
    next_r = r;
    base = (r.ctrl2[SADC_SPLIT_BUFFER_MODE_B] && r.half) ? SADC_HALF_WORDS : 4'h0;
    slot = 4'(base + r.wr_ptr);
    if (rd_acc) begin
      if (paddr == SADC_OFF_CTRL2) begin
        next_r.rdata = {16'h0, r.ctrl2[15:8], r.half & r.ctrl2[SADC_SPLIT_BUFFER_MODE_B], 1'b0, r.ctrl2[5:0]};
      end else if (paddr == SADC_OFF_MUXA) begin
        next_r.rdata = {23'h0, r.mux_a};
      end else if (paddr == SADC_OFF_MUXB) begin
        next_r.rdata = {23'h0, r.mux_b};
      end else if (paddr == SADC_OFF_SCAN) begin
        next_r.rdata = {16'h0, r.scan_mask};
      end else if (paddr == SADC_OFF_FORMAT) begin
        next_r.rdata = {29'h0, r.format};
      end else if (paddr == SADC_OFF_STATUS) begin
        next_r.rdata = {29'h0, busy, r.irq_status};
      end else if (paddr == SADC_OFF_IRQEN) begin
        next_r.rdata = {30'h0, r.irq_en};
      end else if (paddr >= SADC_OFF_BUF && paddr <= SADC_OFF_BUF_END) begin
        next_r.rdata = fmt(r.format, r.buffer[paddr[5:2]*RES_BITS +: RES_BITS]);
      end else begin
        next_r.rdata = 32'h0;
      end
    end
    if (wr_acc) begin
      if (paddr == SADC_OFF_CTRL2) begin
        next_r.ctrl2 = (pwdata[15:0] & SADC_CTRL2_WMASK);
        next_r.use_b = 1'b0;
        // restart the fill so a smaller count or split mode sees no stale pointer, except when a conversion completes in the same cycle
        next_r.wr_ptr  = 4'h0;
        next_r.seq_cnt = 4'h0;
      end else if (paddr == SADC_OFF_MUXA) begin
        next_r.mux_a = pwdata[8:0];
      end else if (paddr == SADC_OFF_MUXB) begin
        next_r.mux_b = pwdata[8:0];
      end else if (paddr == SADC_OFF_SCAN) begin
        next_r.scan_mask = pwdata[15:0];
        next_r.scan_ch   = next_scan(pwdata[15:0], 4'hf);
      end else if (paddr == SADC_OFF_FORMAT) begin
        next_r.format = pwdata[2:0];
      end else if (paddr == SADC_OFF_IRQEN) begin
        next_r.irq_en = pwdata[1:0] & SADC_IRQ_MASK;
      end else if (paddr == SADC_OFF_IRQCLR) begin
        next_r.irq_status = r.irq_status & ~pwdata[1:0];
      end else if (paddr == SADC_OFF_START && pwdata[0] && r.state == SADC_IDLE) begin
        next_r.state = SADC_SAMPLE;
      end
    end
    case (r.state)
      SADC_SAMPLE: next_r.state = SADC_WAIT;
      SADC_WAIT: begin
        if (conv_done) begin
          next_r.state = SADC_IDLE;
          next_r.buffer[slot*RES_BITS +: RES_BITS] = conv_result;
          next_r.wr_ptr = 4'(r.wr_ptr + 4'h1);
          if (r.ctrl2[SADC_ALTERNATE_MUX_MODE_B]) begin
            next_r.use_b = !r.use_b;
          end
          if (r.ctrl2[SADC_SCAN_B]) begin
            next_r.scan_ch = next_scan(r.scan_mask, r.scan_ch);
          end
          if (r.seq_cnt == r.ctrl2[SADC_SEQUENCES_PER_IRQ_HI:SADC_SEQUENCES_PER_IRQ_LO]) begin
            next_r.seq_cnt = 4'h0;
            next_r.irq_status[SADC_IRQ_DONE] = 1'b1;
            next_r.wr_ptr = 4'h0;
            if (r.ctrl2[SADC_SPLIT_BUFFER_MODE_B]) begin
              next_r.half = !r.half;
              next_r.irq_status[SADC_IRQ_HALF] = 1'b1;
            end
          end else begin
            next_r.seq_cnt = 4'(r.seq_cnt + 4'h1);
            if (r.ctrl2[SADC_SPLIT_BUFFER_MODE_B] && r.wr_ptr == SADC_HALF_WORDS - 4'h1) begin
              next_r.wr_ptr = 4'h0;
            end
          end
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{state: SADC_IDLE, ctrl2: SADC_CTRL2_RST, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // ===========================================
  // checks
  upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == SADC_OFF_CTRL2) |=> prdata[31:16] == 16'h0)
    else $error("control two upper half not zero");
  offset_cal_mode_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.ctrl2[SADC_OFFSET_CAL_MODE_B] |-> neg_is_ref_low && pos_channel == 4'h0)
    else $error("offset calibration not tied low");
  ref_both_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.ctrl2[SADC_REF_SELECT_HI] |-> !ref_high_choice && !ref_low_choice)
    else $error("supply references not chosen");
  ref_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.ctrl2[SADC_REF_SELECT_HI:SADC_REF_SELECT_LO] == SADC_REF_SELECT_EXT_HIGH |-> ref_high_choice && !ref_low_choice)
    else $error("external high reference wrong");
  irq_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == SADC_WAIT && conv_done && r.ctrl2[5:2] == 4'h0) |=> r.irq_status[SADC_IRQ_DONE])
    else $error("interrupt not raised after sequence");
  ptr_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == SADC_WAIT && conv_done && r.seq_cnt != r.ctrl2[5:2] && !r.ctrl2[SADC_SPLIT_BUFFER_MODE_B])
    |=> r.wr_ptr == 4'($past(r.wr_ptr) + 4'h1))
    else $error("write pointer did not advance");
  alt_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == SADC_WAIT && conv_done && r.ctrl2[SADC_ALTERNATE_MUX_MODE_B] && !wr_acc) |=> r.use_b != $past(r.use_b))
    else $error("mux set did not alternate");
  no_alt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!r.ctrl2[SADC_ALTERNATE_MUX_MODE_B] && !r.use_b) |=> !r.use_b)
    else $error("second set used without alternate mode");
  half_split_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.ctrl2[SADC_SPLIT_BUFFER_MODE_B] |-> r.wr_ptr < SADC_HALF_WORDS)
    else $error("split half overrun");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(r.irq_status & r.irq_en))
    else $error("interrupt output mismatch");
  // ===========================================
  // steering, storage and event checks
  pready_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pslverr)
    else $error("bus response not zero wait");
  sample_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    sample_hold |=> !sample_hold)
    else $error("sample strobe longer than one cycle");
  wait_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == SADC_WAIT && !conv_done) |=> r.state == SADC_WAIT)
    else $error("conversion left before done");
  ref_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.ctrl2[SADC_REF_SELECT_HI:SADC_REF_SELECT_LO] == SADC_REF_SELECT_BOTH_EXT |-> ref_high_choice && ref_low_choice)
    else $error("external pair not chosen");
  ref_low_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.ctrl2[SADC_REF_SELECT_HI:SADC_REF_SELECT_LO] == SADC_REF_SELECT_EXT_LOW |-> !ref_high_choice && ref_low_choice)
    else $error("external low reference wrong");
  ref_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.ctrl2[SADC_REF_SELECT_HI:SADC_REF_SELECT_LO] == 3'h0 |-> !ref_high_choice && !ref_low_choice)
    else $error("code zero not supply");
  neg_onehot_a: assert property (@(posedge pclk) disable iff (!presetn)
    neg_is_ref_low != neg_channel_one)
    else $error("negative input selection ambiguous");
  diff_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!r.ctrl2[SADC_OFFSET_CAL_MODE_B] && ref_low_choice && pos_channel == 4'h1) |-> neg_is_ref_low)
    else $error("differential on reference pin");
  mux_pos_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!r.ctrl2[SADC_OFFSET_CAL_MODE_B] && !r.ctrl2[SADC_SCAN_B]) |-> pos_channel == cur_mux[3:0])
    else $error("positive input not from mux set");
  scan_pos_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!r.ctrl2[SADC_OFFSET_CAL_MODE_B] && r.ctrl2[SADC_SCAN_B]) |-> pos_channel == r.scan_ch)
    else $error("positive input not from scan");
  scan_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.scan_mask[r.scan_ch] && !wr_acc) |=> r.scan_mask[r.scan_ch])
    else $error("scan moved to unflagged channel");
  store_res_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == SADC_WAIT && conv_done) |=> r.buffer[$past(slot)*RES_BITS +: RES_BITS] == $past(conv_result))
    else $error("result not stored");
  fmt_int_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr >= SADC_OFF_BUF && paddr <= SADC_OFF_BUF_END && r.format == 3'h0) |=> prdata[31:10] == 22'h0)
    else $error("integer format not zero extended");
  half_fill_status_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_acc && paddr == SADC_OFF_CTRL2 && !r.ctrl2[SADC_SPLIT_BUFFER_MODE_B]) |=> !prdata[SADC_HALF_FILL_STATUS_B])
    else $error("fill status set without split mode");
  half_flip_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == SADC_WAIT && conv_done && r.ctrl2[SADC_SPLIT_BUFFER_MODE_B] && r.seq_cnt == r.ctrl2[5:2]) |=> r.half != $past(r.half))
    else $error("split half did not swap");
  ptr_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == SADC_WAIT && conv_done && r.ctrl2[SADC_SPLIT_BUFFER_MODE_B] && r.wr_ptr == 4'h7) |=> r.wr_ptr == 4'h0)
    else $error("split pointer did not wrap");
  irq_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.irq_status[SADC_IRQ_DONE] && !(wr_acc && paddr == SADC_OFF_IRQCLR)) |=> r.irq_status[SADC_IRQ_DONE])
    else $error("status bit not sticky");
  irq_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == SADC_OFF_IRQCLR && pwdata[0] && !(r.state == SADC_WAIT && conv_done)) |=> !r.irq_status[0])
    else $error("status bit not cleared");
  reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.ctrl2 & ~SADC_CTRL2_WMASK) == 16'h0)
    else $error("unimplemented control bit set");
  seq_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    r.seq_cnt <= r.ctrl2[SADC_SEQUENCES_PER_IRQ_HI:SADC_SEQUENCES_PER_IRQ_LO])
    else $error("sequence count past limit");
  alt_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_acc && paddr == SADC_OFF_CTRL2) |=> !r.use_b)
    else $error("alternate not restarted on set a");
  busy_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (r.state == SADC_WAIT && conv_done) |=> !busy)
    else $error("busy after conversion done");
  conv_c:  cover property (@(posedge pclk) r.state == SADC_WAIT && conv_done);
  alt_c:   cover property (@(posedge pclk) r.use_b && sample_hold);
  scan_c:  cover property (@(posedge pclk) r.ctrl2[SADC_SCAN_B] && conv_done && r.state == SADC_WAIT);
  split_c: cover property (@(posedge pclk) r.half && r.ctrl2[SADC_SPLIT_BUFFER_MODE_B]);
  irq_c:   cover property (@(posedge pclk) irq);
endmodule
`default_nettype wire

// File: verification/sadc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// analog core stand-in: converts after a fixed latency
module sadc_analog_model #(
  parameter int LATENCY = 12
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       sample_hold,
  input  wire logic [3:0] pos_channel,
  output logic            conv_done,
  output logic [9:0]      conv_result
);
  int         cnt;
  logic [3:0] held_ch;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt         <= 0;
      conv_done   <= 1'b0;
      conv_result <= 10'h155;
    end else begin
      conv_done <= 1'b0;
      // between results the data lines flip so a stale sample cannot pass
      conv_result <= ~conv_result;
      if (sample_hold) begin
        held_ch <= pos_channel;
        cnt     <= LATENCY;
      end else if (cnt == 1) begin
        conv_done   <= 1'b1;
        conv_result <= {held_ch, 6'h2a};
        cnt         <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/sadc_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl_tb_top;
  import sadc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, neg_is_ref_low, neg_channel_one, sample_hold;
  logic        conv_done, ref_high_choice, ref_low_choice, busy, irq;
  logic [31:0] prdata;
  logic [3:0]  pos_channel;
  logic [9:0]  conv_result;
  logic [31:0] rd;
  int          failures = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #5 pclk = ~pclk;
  sadc_ctrl sadc_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .pos_channel(pos_channel), .neg_is_ref_low(neg_is_ref_low), .neg_channel_one(neg_channel_one),
    .sample_hold(sample_hold), .conv_done(conv_done), .conv_result(conv_result),
    .ref_high_choice(ref_high_choice), .ref_low_choice(ref_low_choice), .busy(busy), .irq(irq));
  sadc_analog_model sadc_analog_model_inst (.pclk(pclk), .presetn(presetn), .sample_hold(sample_hold),
    .pos_channel(pos_channel), .conv_done(conv_done), .conv_result(conv_result));
  // ==========================================
  // reporting
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end
  // ==========================================
  // apb master: hold the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd);
  endtask
  task automatic convert();
    wr(SADC_OFF_START, 32'h1);
    @(posedge pclk);
    check({30'h0, sample_hold, busy}, 32'h3, "sample strobe and busy");
    while (busy !== 1'b0) @(posedge pclk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_ctrl2();
    apb(1'b0, SADC_OFF_CTRL2, 32'h0, rd);
    check(rd, 32'h0, "ctrl2 reset");
    wr(SADC_OFF_CTRL2, 32'hffffffff);
    apb(1'b0, SADC_OFF_CTRL2, 32'h0, rd);
    check(rd, 32'h0000f43f, "ctrl2 writable bits");
    apb(1'b0, 8'h30, 32'h0, rd);
    check(rd, 32'h0, "unmapped read");
    for (int c = 0; c < 8; c++) begin
      wr(SADC_OFF_CTRL2, 32'(c) << 13);
      @(posedge pclk);
      check({31'h0, ref_high_choice}, {31'h0, c == 3 || c == 1}, "ref high");
      check({31'h0, ref_low_choice}, {31'h0, c == 3 || c == 2}, "ref low");
    end
    wr(SADC_OFF_CTRL2, 32'h1000);
    @(posedge pclk);
    check({31'h0, neg_is_ref_low}, 32'h1, "offset cal negative");
    check({28'h0, pos_channel}, 32'h0, "offset cal positive");
  endtask
  task automatic t_single_irq();
    wr(SADC_OFF_CTRL2, 32'h0);
    wr(SADC_OFF_MUXA, 32'h5);
    wr(SADC_OFF_IRQEN, 32'h1);
    for (int f = 0; f < 8; f += 4) begin
      wr(SADC_OFF_FORMAT, 32'(f));
      convert();
      apb(1'b0, SADC_OFF_BUF, 32'h0, rd);
      check(rd, {22'h0, 4'h5, 6'h2a}, "unsigned result");
      check({31'h0, irq}, 32'h1, "irq after one sequence");
      wr(SADC_OFF_IRQCLR, 32'h3);
      @(posedge pclk);
      check({31'h0, irq}, 32'h0, "irq cleared");
    end
    wr(SADC_OFF_IRQEN, 32'h0);
    convert();
    check({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b0, SADC_OFF_STATUS, 32'h0, rd);
    check({31'h0, rd[0]}, 32'h1, "status sticky");
    wr(SADC_OFF_IRQCLR, 32'h3);
  endtask
  task automatic t_alternate();
    wr(SADC_OFF_FORMAT, 32'h0);
    wr(SADC_OFF_MUXA, 32'h3);
    wr(SADC_OFF_MUXB, 32'h9);
    wr(SADC_OFF_IRQEN, 32'h1);
    wr(SADC_OFF_CTRL2, 32'h5);
    convert();
    check({31'h0, irq}, 32'h0, "no irq after first of two");
    convert();
    check({31'h0, irq}, 32'h1, "irq after second");
    apb(1'b0, SADC_OFF_BUF, 32'h0, rd);
    check(rd, {22'h0, 4'h3, 6'h2a}, "first sample set a");
    apb(1'b0, SADC_OFF_BUF + 8'h4, 32'h0, rd);
    check(rd, {22'h0, 4'h9, 6'h2a}, "second sample set b");
  endtask
  task automatic t_scan_split();
    wr(SADC_OFF_CTRL2, 32'h0);
    wr(SADC_OFF_MUXA, 32'h103);
    @(posedge pclk);
    check({31'h0, neg_channel_one}, 32'h1, "differential negative");
    check({28'h0, pos_channel}, 32'h3, "mux a positive");
    wr(SADC_OFF_CTRL2, 32'h6000);
    wr(SADC_OFF_MUXA, 32'h101);
    @(posedge pclk);
    check({31'h0, neg_is_ref_low}, 32'h1, "reference pin not differential");
    wr(SADC_OFF_IRQCLR, 32'h3);
    wr(SADC_OFF_IRQEN, 32'h3);
    wr(SADC_OFF_SCAN, 32'h24);
    wr(SADC_OFF_CTRL2, 32'h406);
    @(posedge pclk);
    check({28'h0, pos_channel}, 32'h2, "scan first flagged");
    convert();
    check({28'h0, pos_channel}, 32'h5, "scan next flagged");
    convert();
    apb(1'b0, SADC_OFF_CTRL2, 32'h0, rd);
    check(rd, 32'h486, "upper half filling");
    apb(1'b0, SADC_OFF_STATUS, 32'h0, rd);
    check(rd, 32'h3, "both events idle");
    convert();
    wr(SADC_OFF_FORMAT, 32'h1);
    apb(1'b0, SADC_OFF_BUF + 8'h20, 32'h0, rd);
    check(rd, 32'h0000feaa, "signed integer upper half");
    wr(SADC_OFF_FORMAT, 32'h6);
    apb(1'b0, SADC_OFF_BUF + 8'h4, 32'h0, rd);
    check(rd, 32'h5a800000, "fraction second result");
  endtask
  task automatic t_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({30'h0, irq, busy}, 32'h0, "outputs after reset");
    presetn <= 1'b1;
    apb(1'b0, SADC_OFF_CTRL2, 32'h0, rd);
    check(rd, 32'h0, "control two after reset");
    check({30'h0, pready, pslverr}, 32'h2, "bus response");
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_ctrl2();
    t_single_irq();
    t_alternate();
    t_scan_split();
    t_reset();
    final_report();
  end
endmodule
`default_nettype wire
